// ---- hw/frp_bus_cycle.sv ----
// Timed single read or write cycle on the parallel flash pins.
`timescale 1ns/10ps
module frp_bus_cycle
   import frp_pkg::*;
#(
   parameter int AW = 25,
   parameter int DW = 16
)(
   input  wire logic          i_sys_clk,      // system clock
   input  wire logic          i_srst,         // synchronous reset
   frp_cyc_if.eng             cyc,            // cycle request
   input  wire logic [DW-1:0] i_flash_dq,     // data pins in
   output logic      [AW-1:0] o_flash_addr,   // address pins
   output logic      [DW-1:0] o_flash_dq,     // data pins out
   output logic               o_flash_dq_oe_n,// data drive, low drives
   output logic               o_flash_ce_n,   // chip enable, low
   output logic               o_flash_we_n,   // write enable, low
   output logic               o_flash_oe_n    // output enable, low
);

   typedef enum logic [3:0] {
      E_IDLE  = 4'b0001,
      E_SETUP = 4'b0010,
      E_STRB  = 4'b0100,
      E_HOLD  = 4'b1000
   } frp_eng_t;

   frp_eng_t      state_r;
   frp_eng_t      state_nxt;
   logic [7:0]    cnt_r;
   logic [7:0]    cnt_nxt;
   logic          wr_r;
   logic [AW-1:0] addr_r;
   logic [DW-1:0] wdata_r;
   logic [DW-1:0] rdata_r;

   wire accept   = (state_r == E_IDLE) && cyc.req;
   wire cnt_end  = (cnt_r == 8'h00);
   wire sample   = (state_r == E_STRB) && cnt_end && !wr_r;

   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_end ? 8'h00 : cnt_r - 8'h01;
      case (state_r)
         E_IDLE:
         begin
            if (cyc.req)
            begin
               state_nxt = E_SETUP;
               cnt_nxt   = 8'(SETUP_CYC - 1);
            end
         end
         E_SETUP:
         begin
            if (cnt_end)
            begin
               state_nxt = E_STRB;
               cnt_nxt   = 8'(STROBE_CYC - 1);
            end
         end
         E_STRB:
         begin
            if (cnt_end)
            begin
               state_nxt = E_HOLD;
               cnt_nxt   = 8'(HOLD_CYC - 1);
            end
         end
         E_HOLD:
         begin
            if (cnt_end)
               state_nxt = E_IDLE;
         end
         default:
         begin
            state_nxt = E_IDLE;
            cnt_nxt   = 8'h00;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         state_r <= E_IDLE;
         cnt_r   <= 8'h00;
         wr_r    <= 1'b0;
         addr_r  <= '0;
         wdata_r <= '0;
         rdata_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         if (accept)
         begin
            wr_r    <= cyc.wr;
            addr_r  <= cyc.addr;
            wdata_r <= cyc.wdata;
         end
         if (sample)
            rdata_r <= i_flash_dq;
      end
   end

   // Data drive spans the whole write so the device latches stable data.
   assign cyc.done        = (state_r == E_HOLD) && cnt_end;
   assign cyc.rdata       = rdata_r;
   assign o_flash_addr    = addr_r;
   assign o_flash_dq      = wdata_r;
   assign o_flash_dq_oe_n = !(wr_r && (state_r != E_IDLE));
   assign o_flash_ce_n    = (state_r == E_IDLE);
   assign o_flash_we_n    = !((state_r == E_STRB) && wr_r);
   assign o_flash_oe_n    = !((state_r == E_STRB) && !wr_r);

endmodule

// ---- hw/frp_ctrl.sv ----
// Host controller that configures and watches the flash status pin.
`timescale 1ns/10ps
module frp_ctrl
   import frp_pkg::*;
#(
   parameter int AW = 25,
   parameter int DW = 16
)(
   input  wire logic          i_sys_clk,      // system clock
   input  wire logic          i_srst,         // synchronous reset
   input  wire logic [7:0]    i_reg_addr,     // register byte address
   input  wire logic [31:0]   i_reg_wdata,    // register write data
   input  wire logic          i_reg_wr,       // write strobe
   input  wire logic          i_reg_rd,       // read strobe
   output logic      [31:0]   o_reg_rdata,    // read data, next cycle
   output logic               o_irq,          // interrupt level
   output logic               o_hold,         // hold to memory controller
   input  wire logic          i_ready_event_pin, // device status pin
   output logic               o_hardware_reset_pin_n, // device reset, low
   input  wire logic [DW-1:0] i_flash_dq,     // data pins in
   output logic      [AW-1:0] o_flash_addr,   // address pins
   output logic      [DW-1:0] o_flash_dq,     // data pins out
   output logic               o_flash_dq_oe_n,// data drive, low drives
   output logic               o_flash_ce_n,   // chip enable, low
   output logic               o_flash_we_n,   // write enable, low
   output logic               o_flash_oe_n    // output enable, low
);

   // ------------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------------
   typedef enum logic [7:0] {
      S_IDLE    = 8'b0000_0001,
      S_CHK_CMD = 8'b0000_0010,
      S_CHK_RD  = 8'b0000_0100,
      S_SETUP   = 8'b0000_1000,
      S_DATA    = 8'b0001_0000,
      S_VER_CMD = 8'b0010_0000,
      S_VER_RD  = 8'b0100_0000,
      S_RESET   = 8'b1000_0000
   } frp_seq_t;

   frp_cyc_if #(.AW(AW), .DW(DW)) cyc ();

   frp_seq_t        state_r;
   frp_seq_t        state_nxt;
   logic            issued_r;
   logic [1:0]      code_r;
   logic [1:0]      mode_r;
   logic [AW-1:0]   dev_addr_r;
   logic [15:0]     srcmd_r;
   logic [7:0]      sr_r;
   logic [7:0]      rst_cnt_r;
   logic [EV_W-1:0] irq_stat_r;
   logic [EV_W-1:0] irq_stat_nxt;
   logic [EV_W-1:0] irq_mask_r;
   logic            pin_d_r;
   logic [15:0]     low_cnt_r;
   logic [15:0]     pwidth_r;
   logic [31:0]     rdata_r;

   // ------------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------------
   wire wr_ctrl   = i_reg_wr && (i_reg_addr == OFS_CTRL);
   wire wr_code   = i_reg_wr && (i_reg_addr == OFS_CODE);
   wire wr_addr   = i_reg_wr && (i_reg_addr == OFS_ADDR);
   wire wr_srcmd  = i_reg_wr && (i_reg_addr == OFS_SRCMD);
   wire wr_istat  = i_reg_wr && (i_reg_addr == OFS_IRQ_STAT);
   wire wr_imask  = i_reg_wr && (i_reg_addr == OFS_IRQ_MASK);
   wire go_req    = wr_ctrl && i_reg_wdata[CTRL_GO_BIT];
   wire rst_req   = wr_ctrl && i_reg_wdata[CTRL_RST_BIT];
   wire seq_idle  = (state_r == S_IDLE);

   // Code 10 is never sent; the device would only flag it as invalid.
   wire code_bad  = (code_r == CODE_PROG_ONLY);
   wire start_ok  = seq_idle && go_req && !rst_req && !code_bad;
   wire start_bad = seq_idle && go_req && !rst_req && code_bad;

   // ------------------------------------------------------------------
   // Flash cycle requests
   // ------------------------------------------------------------------
   wire is_write  = (state_r == S_CHK_CMD) || (state_r == S_SETUP) ||
                    (state_r == S_DATA) || (state_r == S_VER_CMD);
   wire is_read   = (state_r == S_CHK_RD) || (state_r == S_VER_RD);
   wire cyc_done  = cyc.done && issued_r;

   // Device counts busy or either suspend as not ready for configuration.
   wire dev_free  = cyc.rdata[SR_READY_BIT] &&
                    !cyc.rdata[SR_ESUSP_BIT] &&
                    !cyc.rdata[SR_PSUSP_BIT];
   wire dev_inval = cyc.rdata[SR_ERASE_ERR] &&
                    cyc.rdata[SR_PROG_ERR];

   logic [15:0] cyc_wdata;
   always_comb
   begin
      case (state_r)
         S_SETUP:  cyc_wdata = CMD_PIN_SETUP;
         S_DATA:   cyc_wdata = {14'h0000, code_r};
         default:  cyc_wdata = srcmd_r;
      endcase
   end

   // The setup and data writes share one address so the die select bit
   // cannot change between them; each die needs its own run.
   assign cyc.req   = (is_write || is_read) && !issued_r;
   assign cyc.wr    = is_write;
   assign cyc.addr  = dev_addr_r;
   assign cyc.wdata = cyc_wdata[DW-1:0];

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE:
         begin
            if (rst_req)
               state_nxt = S_RESET;
            else if (start_ok)
               state_nxt = S_CHK_CMD;
         end
         S_CHK_CMD:
            if (cyc_done)
               state_nxt = S_CHK_RD;
         S_CHK_RD:
            if (cyc_done)
               state_nxt = dev_free ? S_SETUP : S_IDLE;
         S_SETUP:
            if (cyc_done)
               state_nxt = S_DATA;
         S_DATA:
            if (cyc_done)
               state_nxt = S_VER_CMD;
         S_VER_CMD:
            if (cyc_done)
               state_nxt = S_VER_RD;
         S_VER_RD:
            if (cyc_done)
               state_nxt = S_IDLE;
         S_RESET:
            if (rst_cnt_r == 8'h00)
               state_nxt = S_IDLE;
         default:
            state_nxt = S_IDLE;
      endcase
   end

   wire ev_done    = (state_r == S_VER_RD) && cyc_done && !dev_inval;
   wire ev_dev_err = (state_r == S_VER_RD) && cyc_done && dev_inval;
   wire ev_refused = start_bad ||
                     ((state_r == S_CHK_RD) && cyc_done && !dev_free);
   wire mode_load  = (state_r == S_DATA) && cyc_done;

   // ------------------------------------------------------------------
   // Status pin monitor
   // ------------------------------------------------------------------
   wire pulse_mode = (mode_r != CODE_LEVEL);
   wire pin_rise   = !pin_d_r && i_ready_event_pin;
   // In pulse modes a low is a completion event, never a busy level.
   wire ev_pulse   = pulse_mode && pin_rise;
   wire ev_ready   = !pulse_mode && pin_rise;
   wire [15:0] low_inc = (low_cnt_r == 16'hFFFF) ?
                         low_cnt_r : low_cnt_r + 16'h0001;

   wire [EV_W-1:0] ev_vec = {ev_ready, ev_pulse, ev_dev_err,
                             ev_refused, ev_done};
   // A new event outranks a clear written in the same cycle.
   always_comb
   begin
      irq_stat_nxt = irq_stat_r;
      if (wr_istat)
         irq_stat_nxt = irq_stat_r & ~i_reg_wdata[EV_W-1:0];
      irq_stat_nxt = irq_stat_nxt | ev_vec;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         state_r  <= S_IDLE;
         issued_r <= 1'b0;
      end
      else
      begin
         state_r  <= state_nxt;
         issued_r <= cyc_done ? 1'b0 : (issued_r || cyc.req);
      end
   end

   // The mirror follows the device: default after i_srst or any hardware reset,
   // otherwise only a completed data write changes it.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst || (state_r == S_RESET))
         mode_r <= CODE_LEVEL;
      else if (mode_load)
         mode_r <= code_r;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         rst_cnt_r <= 8'h00;
      else if (seq_idle && rst_req)
         rst_cnt_r <= 8'(RESET_CYC - 1);
      else if (rst_cnt_r != 8'h00)
         rst_cnt_r <= rst_cnt_r - 8'h01;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         code_r     <= CODE_LEVEL;
         dev_addr_r <= '0;
         srcmd_r    <= SRCMD_RESET;
         irq_mask_r <= '0;
      end
      else
      begin
         if (wr_code && seq_idle)
            code_r <= i_reg_wdata[1:0];
         if (wr_addr && seq_idle)
            dev_addr_r <= i_reg_wdata[AW-1:0];
         if (wr_srcmd)
            srcmd_r <= i_reg_wdata[15:0];
         if (wr_imask)
            irq_mask_r <= i_reg_wdata[EV_W-1:0];
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         sr_r <= 8'h00;
      else if (is_read && cyc_done)
         sr_r <= cyc.rdata[7:0];
   end

   // Low width of the last pulse, to compare with the nominal figure.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         pin_d_r   <= 1'b1;
         low_cnt_r <= 16'h0000;
         pwidth_r  <= 16'h0000;
      end
      else
      begin
         pin_d_r   <= i_ready_event_pin;
         low_cnt_r <= i_ready_event_pin ? 16'h0000 : low_inc;
         if (ev_pulse)
            pwidth_r <= low_cnt_r;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         irq_stat_r <= '0;
      else
         irq_stat_r <= irq_stat_nxt;
   end

   // ------------------------------------------------------------------
   // Read back
   // ------------------------------------------------------------------
   wire [31:0] status_word = {16'h0000, sr_r, 3'h0,
                              i_ready_event_pin, mode_r,
                              (state_r == S_RESET), !seq_idle};
   logic [31:0] rd_mux;
   always_comb
   begin
      case (i_reg_addr)
         OFS_CODE:     rd_mux = {30'h0, code_r};
         OFS_ADDR:     rd_mux = 32'(dev_addr_r);
         OFS_SRCMD:    rd_mux = {16'h0000, srcmd_r};
         OFS_STATUS:   rd_mux = status_word;
         OFS_IRQ_STAT: rd_mux = 32'(irq_stat_r);
         OFS_IRQ_MASK: rd_mux = 32'(irq_mask_r);
         OFS_PWIDTH:   rd_mux = {16'h0000, pwidth_r};
         default:      rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         rdata_r <= 32'h0000_0000;
      else
         rdata_r <= i_reg_rd ? rd_mux : 32'h0000_0000;
   end

   assign o_reg_rdata            = rdata_r;
   assign o_irq                  = |(irq_stat_r & irq_mask_r);
   assign o_hold                 = !pulse_mode &&
                                   !i_ready_event_pin;
   assign o_hardware_reset_pin_n = !(state_r == S_RESET);

   // ------------------------------------------------------------------
   // Flash cycle engine
   // ------------------------------------------------------------------
   frp_bus_cycle #(
      .AW (AW),
      .DW (DW)
   ) u_cycle (
      .i_sys_clk       (i_sys_clk),
      .i_srst          (i_srst),
      .cyc             (cyc),
      .i_flash_dq      (i_flash_dq),
      .o_flash_addr    (o_flash_addr),
      .o_flash_dq      (o_flash_dq),
      .o_flash_dq_oe_n (o_flash_dq_oe_n),
      .o_flash_ce_n    (o_flash_ce_n),
      .o_flash_we_n    (o_flash_we_n),
      .o_flash_oe_n    (o_flash_oe_n)
   );

endmodule

// ---- hw/frp_cyc_if.sv ----
// Request and answer signals of one flash bus cycle.
`timescale 1ns/10ps
interface frp_cyc_if #(
   parameter int AW = 25,
   parameter int DW = 16
);
   logic          req;
   logic          wr;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic          done;
   logic [DW-1:0] rdata;

   modport ctl (output req, output wr, output addr, output wdata,
                input done, input rdata);
   modport eng (input req, input wr, input addr, input wdata,
                output done, output rdata);
endinterface

// ---- hw/frp_pkg.sv ----
// Constants and register map of the status pin configuration controller.
package frp_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int T_SETUP_NS    = 20;
   localparam int T_STROBE_NS   = 80;
   localparam int T_HOLD_NS     = 20;
   localparam int T_RESET_NS    = 100;
   localparam int T_PULSE_NS    = 250;
   localparam int SETUP_CYC  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC   = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_CYC  = (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_CYC  = T_PULSE_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------------
   // Device command codes and status register bits
   // ------------------------------------------------------------------
   localparam logic [15:0] CMD_PIN_SETUP  = 16'h00B8;
   localparam logic [1:0]  CODE_LEVEL     = 2'h0;
   localparam logic [1:0]  CODE_PROG_ONLY = 2'h2;
   localparam int          CODE_ERASE_BIT = 0;
   localparam int          CODE_PROG_BIT  = 1;
   localparam int          SR_READY_BIT   = 7;
   localparam int          SR_ESUSP_BIT   = 6;
   localparam int          SR_ERASE_ERR   = 5;
   localparam int          SR_PROG_ERR    = 4;
   localparam int          SR_PSUSP_BIT   = 2;

   // ------------------------------------------------------------------
   // Controller registers, byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_CODE     = 8'h04;
   localparam logic [7:0] OFS_ADDR     = 8'h08;
   localparam logic [7:0] OFS_SRCMD    = 8'h0C;
   localparam logic [7:0] OFS_STATUS   = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFS_PWIDTH   = 8'h1C;
   localparam int CTRL_GO_BIT  = 0;
   localparam int CTRL_RST_BIT = 1;
   localparam logic [15:0] SRCMD_RESET = 16'h0000;

   // Event bits of the interrupt status and mask registers.
   localparam int EV_DONE    = 0;
   localparam int EV_REFUSED = 1;
   localparam int EV_DEV_ERR = 2;
   localparam int EV_PULSE   = 3;
   localparam int EV_READY   = 4;
   localparam int EV_W       = 5;

endpackage

// ---- tb/frp_ctrl_checker.sv ----
// Pin-level checker of the status pin controller.
`timescale 1ns/10ps
module frp_ctrl_checker #(
   parameter int AW = 25
)(
   input wire logic          i_sys_clk,         // clock
   input wire logic          i_srst,            // reset
   input wire logic          i_reg_rd,          // read strobe
   input wire logic [31:0]   o_reg_rdata,       // read data
   input wire logic          o_hold,            // hold out
   input wire logic          i_ready_event_pin, // status pin
   input wire logic          o_hardware_reset_pin_n, // reset out
   input wire logic [AW-1:0] o_flash_addr,      // address
   input wire logic          o_flash_dq_oe_n,   // data drive
   input wire logic          o_flash_ce_n,      // chip enable
   input wire logic          o_flash_we_n,      // write enable
   input wire logic          o_flash_oe_n       // output enable
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   AST_RDATA_ZERO: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 0)
      else $error("read data outside answer cycle");
   AST_HOLD_PIN: assert property (
      i_ready_event_pin [*4] |-> !o_hold)
      else $error("hold while pin high");
   AST_NO_CONTEND: assert property (
      !o_flash_dq_oe_n |-> o_flash_oe_n)
      else $error("data driven during read");
   AST_WE_QUAL: assert property (
      !o_flash_we_n |-> !o_flash_ce_n && !o_flash_dq_oe_n)
      else $error("write strobe without select");
   AST_CE_SETUP: assert property (
      $fell(o_flash_ce_n) |-> (o_flash_we_n && o_flash_oe_n) [*5])
      else $error("strobe too early");
   AST_WE_WIDTH: assert property (
      $fell(o_flash_we_n) |->
      (!o_flash_we_n) [*8] ##12 !o_flash_we_n ##1 o_flash_we_n)
      else $error("write strobe width");
   AST_ADDR_STABLE: assert property (
      !o_flash_ce_n && !$past(o_flash_ce_n) |-> $stable(o_flash_addr))
      else $error("address moved in cycle");
   AST_RST_WIDTH: assert property (
      $fell(o_hardware_reset_pin_n) |-> (!o_hardware_reset_pin_n) [*8]
      ##17 !o_hardware_reset_pin_n ##1 o_hardware_reset_pin_n)
      else $error("reset pulse width");
   AST_RST_VALUE: assert property (
      $past(i_srst) |-> o_flash_ce_n && o_flash_we_n &&
      o_hardware_reset_pin_n)
      else $error("pins not idle after reset");
   COV_WRITE: cover property ($fell(o_flash_we_n));
   COV_RESET: cover property ($fell(o_hardware_reset_pin_n));
   COV_HOLD: cover property ($rose(o_hold));
endmodule

bind frp_ctrl frp_ctrl_checker #(.AW(AW)) i_frp_ctrl_checker (
   .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_reg_rd(i_reg_rd),
   .o_reg_rdata(o_reg_rdata), .o_hold(o_hold),
   .i_ready_event_pin(i_ready_event_pin),
   .o_hardware_reset_pin_n(o_hardware_reset_pin_n),
   .o_flash_addr(o_flash_addr), .o_flash_dq_oe_n(o_flash_dq_oe_n),
   .o_flash_ce_n(o_flash_ce_n), .o_flash_we_n(o_flash_we_n),
   .o_flash_oe_n(o_flash_oe_n));

// ---- tb/frp_flash_model.sv ----
// Behavioural flash device: status pin setup and status reads.
`timescale 1ns/10ps
module frp_flash_model
   import frp_pkg::*;
(
   input  wire logic        i_sys_clk,    // model clock
   input  wire logic        i_rst_n,      // device reset, low
   input  wire logic [24:0] i_addr,       // address pins
   input  wire logic [15:0] i_dq,         // resolved data wire
   input  wire logic        i_ce_n,       // chip enable, low
   input  wire logic        i_we_n,       // write enable, low
   input  wire logic        i_oe_n,       // output enable, low
   input  wire logic        i_busy,       // state machine busy
   input  wire logic        i_erase_done, // erase completes
   input  wire logic        i_prog_done,  // program completes
   output logic      [15:0] o_dq,         // data out
   output logic             o_pin,        // status pin
   output logic      [1:0]  o_cfg,        // pin setup held
   output logic             o_same        // data write at setup address
);
   logic        we_q   = 1'b1;
   logic        arm_r  = 1'b0;
   logic [1:0]  cfg_r  = 2'h0;
   logic        same_r = 1'b0;
   logic [1:0]  err_r  = 2'h0;
   logic [7:0]  pcnt_r = 8'h00;
   logic [24:0] sa_r   = 25'h0;
   logic [15:0] last_r = 16'h0000;
   wire         wr_edge = !we_q && i_we_n && !i_ce_n;
   wire  [7:0]  sr = {!i_busy, 1'b0, err_r, 4'h0};
   // Lock operations are not modelled, so they never pulse.
   wire  fire = (i_erase_done & cfg_r[0]) |
                (i_prog_done & cfg_r[1]);
   // A released bus flips every cycle so a stale value never passes.
   assign o_dq   = (!i_ce_n && !i_oe_n) ? {8'h00, sr} : ~last_r;
   assign o_cfg  = cfg_r;
   assign o_same = same_r;
   assign o_pin  = (cfg_r == 2'h0) ? !i_busy :
                   (pcnt_r == 8'h00);
   always_ff @(posedge i_sys_clk)
   begin
      we_q   <= i_we_n;
      last_r <= o_dq;
      pcnt_r <= fire ? 8'(PULSE_CYC) : pcnt_r - (pcnt_r != 0);
      if (!i_rst_n)
      begin
         cfg_r <= 2'h0;
         arm_r <= 1'b0;
         err_r <= 2'h0;
      end
      else if (wr_edge && arm_r)
      begin
         arm_r  <= 1'b0;
         same_r <= (i_addr == sa_r);
         if (i_dq[1:0] == 2'h2)
            err_r <= 2'h3;
         else
            cfg_r <= i_dq[1:0];
      end
      else if (wr_edge && i_dq == CMD_PIN_SETUP)
      begin
         arm_r <= 1'b1;
         sa_r  <= i_addr;
      end
   end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the status pin controller.
`timescale 1ns/10ps
module testbench;
   import frp_pkg::*;
   logic        clk = 0, srst = 1, wr = 0, rd = 0;
   logic        busy = 0, e_dn = 0, p_dn = 0;
   logic [7:0]  ra = 8'h00;
   logic [31:0] wd = 32'h0, rdat, d;
   logic        irq, hold, rpn, pin, dqoe, ce, we, oe, same;
   logic [24:0] fa;
   logic [15:0] cdq, mdq, dqw;
   logic [1:0]  cfg;
   int          num_errors = 0, num_checks = 0;
   assign dqw = dqoe ? mdq : cdq;
   always #2 clk = ~clk;
   frp_ctrl i_frp_ctrl (.i_sys_clk(clk), .i_srst(srst), .i_reg_addr(ra),
      .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat),
      .o_irq(irq), .o_hold(hold), .i_ready_event_pin(pin),
      .o_hardware_reset_pin_n(rpn), .i_flash_dq(dqw), .o_flash_addr(fa),
      .o_flash_dq(cdq), .o_flash_dq_oe_n(dqoe), .o_flash_ce_n(ce),
      .o_flash_we_n(we), .o_flash_oe_n(oe));
   frp_flash_model i_frp_flash_model (.i_sys_clk(clk), .i_rst_n(rpn),
      .i_addr(fa), .i_dq(dqw), .i_ce_n(ce), .i_we_n(we), .i_oe_n(oe),
      .i_busy(busy), .i_erase_done(e_dn), .i_prog_done(p_dn), .o_dq(mdq),
      .o_pin(pin), .o_cfg(cfg), .o_same(same));
   // ------------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rw(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      ra <= a;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rr(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      ra <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdat;
   endtask
   task automatic run(input logic [1:0] c, input int b);
      // Level-mode pin edges from earlier scenarios must not linger.
      rw(OFS_IRQ_STAT, 32'h1F);
      rw(OFS_CODE, {30'h0, c});
      rw(OFS_CTRL, 32'h1);
      d = 32'h0;
      for (int n = 0; n < 300 && d[b] !== 1'b1; n++) rr(OFS_IRQ_STAT, d);
      chk(d & 32'h1F, 32'h1 << b);
      rw(OFS_IRQ_STAT, 32'h1F);
   endtask
   task automatic done_ev(input logic er);
      e_dn <= er;
      p_dn <= !er;
      @(posedge clk);
      e_dn <= 1'b0;
      p_dn <= 1'b0;
      repeat (90) @(posedge clk);
      rr(OFS_IRQ_STAT, d);
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic s_default;
      rr(OFS_STATUS, d);
      chk(d & 32'hF, 32'h0);
      busy <= 1'b1;
      repeat (6) @(posedge clk);
      chk({pin, hold}, 2'b01);
      busy <= 1'b0;
   endtask
   task automatic s_refuse;
      busy <= 1'b1;
      run(2'h1, EV_REFUSED);
      busy <= 1'b0;
      run(2'h2, EV_REFUSED);
      chk(cfg, 2'h0);
   endtask
   task automatic s_erase;
      run(2'h1, EV_DONE);
      chk({cfg, same}, 3'b011);
      busy <= 1'b1;
      repeat (8) @(posedge clk);
      chk({pin, hold}, 2'b10);
      busy <= 1'b0;
      done_ev(1'b0);
      chk(d & 32'h8, 32'h0);
      done_ev(1'b1);
      chk(d & 32'h8, 32'h8);
      rw(OFS_IRQ_MASK, 32'h8);
      // The mask and the clear land at the edge; look once they settle.
      #1 chk(irq, 1'b1);
      rw(OFS_IRQ_STAT, 32'h8);
      #1 chk(irq, 1'b0);
      rr(OFS_PWIDTH, d);
      chk(d, PULSE_CYC);
   endtask
   task automatic s_both;
      run(2'h3, EV_DONE);
      done_ev(1'b0);
      chk(d & 32'h8, 32'h8);
      rw(OFS_IRQ_STAT, 32'h1F);
   endtask
   task automatic s_level;
      run(2'h0, EV_DONE);
      rw(OFS_ADDR, 32'h01000000);
      run(2'h0, EV_DONE);
      chk({cfg, same}, 3'b001);
      busy <= 1'b1;
      repeat (6) @(posedge clk);
      chk({pin, hold}, 2'b01);
      busy <= 1'b0;
   endtask
   task automatic s_hw_reset;
      run(2'h3, EV_DONE);
      rw(OFS_CTRL, 32'h2);
      repeat (40) @(posedge clk);
      rr(OFS_STATUS, d);
      chk({d[3:2], cfg}, 4'h0);
   endtask
   task automatic end_of_test;
      $display("Checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #100000;
      num_errors++;
      end_of_test();
   end
   initial
   begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      s_default();
      rw(OFS_SRCMD, 32'h55);
      rw(OFS_ADDR, 32'h0);
      s_refuse();
      s_erase();
      s_both();
      s_level();
      s_hw_reset();
      end_of_test();
   end
endmodule
